/* File: dv/change_detect_interrupt_ctrl_tb_top.sv */
// self-checking bench for the change interrupt controller
`default_nettype none
module change_detect_interrupt_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, nrst_in, wr_in, rd_in, wexp, pend, irq_out;
   logic [7:0]  addr_in, wdata_in, rdata_out;
   logic [95:0] lines_in, route;
   logic [11:0] port_out;
   logic [31:0] seed;
   int          mismatches, n_compared;
   host_model host_u (.clk_in(clk_in), .addr_out(addr_in),
      .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in));
   change_detect_interrupt_ctrl dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .lines_in(lines_in), .port_output_in(port_out),
      .watchdog_expired_in(wexp), .watchdog_kick_out(),
      .watchdog_expiry_clear_out(), .route_lines_out(route),
      .irq_out(irq_out));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic check(input string nm, input logic [95:0] seen,
                        input logic [95:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   // read data stand one cycle only, so compare exactly at that edge
   always @(posedge clk_in)
   begin
      pend <= rd_in;
      if (pend === 1'b1)
         check("rdata", rdata_out, host_u.exp_q.pop_front());
   end
   initial
   begin
      #100000;
      mismatches++;
      conclude();
   end
   initial
   begin
      {nrst_in, wexp, lines_in, port_out} = '0;
      seed = 32'h0D3A;
      cyc(2);
      nrst_in <= 1'b1;
      host_u.rd(8'h00, 8'h5A);
      host_u.rd(8'h02, 8'h00);
      host_u.rd(8'h01, 8'h00);
      host_u.wr(8'h03, 8'hFF);
      host_u.rd(8'h03, 8'h3F);
      port_out <= 12'h002;
      host_u.wr(8'h49, 8'h01);
      host_u.wr(8'h59, 8'hA5);
      host_u.wr(8'hF9, 8'h3C);
      host_u.rd(8'h59, 8'hA5);
      host_u.rd(8'hF9, 8'h3C);
      check("route", route, 96'hA5 << 8);
      port_out <= 12'h003;
      cyc(1);
      check("route0", route, 96'h01);
      host_u.wr(8'h42, 8'h01);
      host_u.wr(8'h43, 8'h01);
      host_u.wr(8'h03, 8'h0C);
      repeat (4)
      begin
         seed = xs(seed);
         lines_in[95:1] <= {seed, seed, seed[30:0]};
         cyc(2);
      end
      cyc(3);
      host_u.rd(8'h02, 8'h00);
      lines_in[0] <= 1'b1;
      cyc(4);
      check("irq", irq_out, 96'h1);
      host_u.rd(8'h02, 8'h0D);
      lines_in[0] <= 1'b0;
      cyc(4);
      host_u.rd(8'h02, 8'h1F);
      host_u.wr(8'h01, 8'h08);
      host_u.rd(8'h02, 8'h02);
      host_u.wr(8'h01, 8'h0C);
      host_u.rd(8'h02, 8'h00);
      host_u.wr(8'h03, 8'h24);
      wexp <= 1'b1;
      cyc(4);
      wexp <= 1'b0;
      host_u.rd(8'h02, 8'h24);
      check("wirq", irq_out, 96'h1);
      host_u.wr(8'h01, 8'h70);
      host_u.rd(8'h02, 8'h00);
      host_u.wr(8'h03, 8'h20);
      wexp <= 1'b1;
      cyc(4);
      wexp <= 1'b0;
      host_u.rd(8'h02, 8'h20);
      cyc(2);
      conclude();
   end
endmodule // change_detect_interrupt_ctrl_tb_top
`default_nettype wire

/* File: dv/change_irq_props.sv */
// port assertions for the change interrupt controller
`default_nettype none
module change_irq_props
#(
   parameter [7:0] BOARD_ID = 8'h5A // arbitrary value
)
(
   input wire logic       clk_in,
   input wire logic       nrst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic       watchdog_kick_out,
   input wire logic       watchdog_expiry_clear_out,
   input wire logic       irq_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   property p_id;
      rd_in && addr_in == 8'h00 |=> rdata_out == BOARD_ID;
   endproperty
   a_id: assert property (p_id) else $error("identity read wrong");
   property p_strobe;
      rd_in && addr_in == 8'h01 |=> rdata_out == 8'h00;
   endproperty
   a_strobe: assert property (p_strobe) else $error("clear reg held");
   property p_kick;
      watchdog_kick_out == (wr_in && addr_in == 8'h01 && wdata_in[5]);
   endproperty
   a_kick: assert property (p_kick) else $error("kick pulse wrong");
   property p_xclr;
      watchdog_expiry_clear_out == (wr_in && addr_in == 8'h01 && wdata_in[4]);
   endproperty
   a_xclr: assert property (p_xclr) else $error("expiry clr wrong");
   property p_gate;
      wr_in && addr_in == 8'h03 && !wdata_in[2] |=> !irq_out;
   endproperty
   a_gate: assert property (p_gate) else $error("irq without gate");
   property p_rst;
      $rose(nrst_in) |-> !irq_out && rdata_out == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("not idle after reset");
   property p_mirror;
      rd_in && addr_in == 8'h02 |=> rdata_out[2] == $past(irq_out);
   endproperty
   a_mirror: assert property (p_mirror) else $error("irq bit wrong");
   property p_noflag;
      rd_in && addr_in == 8'h02 ##1 (rdata_out & 8'h3B) == 8'h00
         |-> !rdata_out[2];
   endproperty
   a_noflag: assert property (p_noflag) else $error("irq, no flag");
   cover property (rd_in && addr_in == 8'h02 ##1 rdata_out[2]);
   cover property ($rose(irq_out));
   cover property ($fell(irq_out));
endmodule // change_irq_props
bind change_detect_interrupt_ctrl change_irq_props #(.BOARD_ID(BOARD_ID))
   chk_u (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .watchdog_kick_out(watchdog_kick_out),
   .watchdog_expiry_clear_out(watchdog_expiry_clear_out), .irq_out(irq_out));
`default_nettype wire

/* File: dv/host_model.sv */
// host side model: register writes and reads, notes expected read data
`default_nettype none
module host_model
(
   input  wire logic       clk_in,
   output var  logic [7:0] addr_out,
   output var  logic [7:0] wdata_out,
   output var  logic       wr_out,
   output var  logic       rd_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] exp_q[$];
   initial {addr_out, wdata_out, wr_out, rd_out} = '0;
   // callers keep reserved bits zero except where a refusal is wanted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_in);
      rd_out <= 1'b0;
   endtask
endmodule // host_model
`default_nettype wire

/* File: hdl/change_detect_interrupt_ctrl.v */
// change-detect and watchdog interrupt controller with register port
//
// Contract
// - read-only identity byte at offset zero
// - clear register is write strobe only
// - clear bit 6 drops watchdog interrupt
// - clear bit 5 restarts watchdog count
// - clear bit 4 ends expiry state
// - clear bit 3 resets edge status, detectors
// - overflow clears only with bits 2,3
// - status bit 5 shows watchdog expiry event
// - status bit 4 shows falling edge seen
// - status bit 3 shows rising edge seen
// - status bit 2 shows interrupt asserted
// - status bit 1 flags edge during interrupt
// - status bit 0 shows edge detected
// - enable bit 5 gates watchdog interrupt
// - enable bit 4 gates falling interrupt
// - enable bit 3 gates rising interrupt
// - enable bits 1,0 gate overflow, edge
// - enable bit 2 gates every interrupt
// - per-port route enable at 0x49+0x10*N
// - routing only first output port, plus line 0 of second on star variant
// - per-port registers for ports 0 to 11
// - rising edge counts when rise watch set
// - falling edge counts when fall watch set
`include "change_irq_regs.vh"
`default_nettype none

module change_detect_interrupt_ctrl
#(
   parameter [7:0] BOARD_ID = `BOARD_ID_DEFAULT, // arbitrary value
   parameter       STAR_VARIANT = 1'b0
)
(
   input  wire        clk_in,
   input  wire        nrst_in,
   input  wire [7:0]  addr_in,
   input  wire [7:0]  wdata_in,
   input  wire        wr_in,
   input  wire        rd_in,
   output reg  [7:0]  rdata_out,
   input  wire [95:0] lines_in,
   input  wire [11:0] port_output_in,
   input  wire        watchdog_expired_in,
   output wire        watchdog_kick_out,
   output wire        watchdog_expiry_clear_out,
   output wire [95:0] route_lines_out,
   output wire        irq_out
);

   // -----------------------------------------------------------
   // address decode helpers
   // -----------------------------------------------------------
   function is_port_reg;
      input [7:0] a;
      input [7:0] base;
      reg   [7:0] d;
      begin
         d = a - base;
         is_port_reg = (a >= base) && (d[3:0] == 4'h0)
                       && (d[7:4] < 4'hC);
      end
   endfunction

   function [3:0] port_of;
      input [7:0] a;
      input [7:0] base;
      reg   [7:0] d;
      begin
         d = a - base;
         port_of = d[7:4];
      end
   endfunction

   // -----------------------------------------------------------
   // storage
   // -----------------------------------------------------------
   reg [7:0]  int_enable_r;
   reg [95:0] rise_watch_r;
   reg [95:0] fall_watch_r;
   reg [95:0] route_en_r;
   reg [95:0] sync1_r;
   reg [95:0] sync2_r;
   reg [95:0] prev_r;
   reg        prev_valid_r;
   reg        wdog_sync1_r;
   reg        wdog_sync2_r;
   reg        wdog_prev_r;
   reg        edge_flag_r;
   reg        rise_flag_r;
   reg        fall_flag_r;
   reg        overrun_flag_r;
   reg        wdog_flag_r;

   wire       wr_clear = wr_in && (addr_in == `ADDR_CLEAR_STROBE);
   // the strobe stores nothing; zero-written bits, bits 7, 1, 0 and bit 2 without bit 3 are ignored
   wire       clr_edge = wr_clear && wdata_in[`CLR_EDGE];
   wire       clr_over = clr_edge && wdata_in[`CLR_OVERRUN];
   wire       clr_wdog = wr_clear && wdata_in[`CLR_WDOG_IRQ];

   assign watchdog_kick_out = wr_clear && wdata_in[`CLR_WDOG_KICK];
   assign watchdog_expiry_clear_out =
      wr_clear && wdata_in[`CLR_WDOG_EXPIRY];

   // -----------------------------------------------------------
   // edge detection
   // -----------------------------------------------------------
   wire [95:0] rise_hit = sync2_r & ~prev_r & rise_watch_r;
   wire [95:0] fall_hit = ~sync2_r & prev_r & fall_watch_r;
   wire        rise_any = prev_valid_r && (|rise_hit);
   wire        fall_any = prev_valid_r && (|fall_hit);
   wire        edge_any = rise_any || fall_any;
   wire        wdog_ev  = wdog_sync2_r && !wdog_prev_r;

   // irq follows the qualified flags; global gate on top
   wire irq_any =
      (edge_flag_r    && int_enable_r[`EN_EDGE])    ||
      (overrun_flag_r && int_enable_r[`EN_OVERRUN]) ||
      (rise_flag_r    && int_enable_r[`EN_RISE])    ||
      (fall_flag_r    && int_enable_r[`EN_FALL])    ||
      (wdog_flag_r    && int_enable_r[`EN_WDOG]);
   assign irq_out = int_enable_r[`EN_GLOBAL] && irq_any;

   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         sync1_r      <= 96'h0;
         sync2_r      <= 96'h0;
         prev_r       <= 96'h0;
         prev_valid_r <= 1'b0;
         wdog_sync1_r <= 1'b0;
         wdog_sync2_r <= 1'b0;
         wdog_prev_r  <= 1'b0;
      end
      else
      begin
         sync1_r      <= lines_in;
         sync2_r      <= sync1_r;
         prev_r       <= sync2_r;
         prev_valid_r <= 1'b1;
         wdog_sync1_r <= watchdog_expired_in;
         wdog_sync2_r <= wdog_sync1_r;
         wdog_prev_r  <= wdog_sync2_r;
      end
   end

   // -----------------------------------------------------------
   // sticky flags; a new event wins over a clear in the same cycle
   // -----------------------------------------------------------
   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         edge_flag_r    <= 1'b0;
         rise_flag_r    <= 1'b0;
         fall_flag_r    <= 1'b0;
         overrun_flag_r <= 1'b0;
         wdog_flag_r    <= 1'b0;
      end
      else
      begin
         // the edge clear also empties the rise and fall detectors
         edge_flag_r <= edge_any || (edge_flag_r && !clr_edge);
         rise_flag_r <= rise_any || (rise_flag_r && !clr_edge);
         fall_flag_r <= fall_any || (fall_flag_r && !clr_edge);
         overrun_flag_r <= (edge_any && irq_out)
                           || (overrun_flag_r && !clr_over);
         wdog_flag_r <= wdog_ev || (wdog_flag_r && !clr_wdog);
      end
   end

   // -----------------------------------------------------------
   // register writes
   // -----------------------------------------------------------
   integer p;
   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         int_enable_r <= `RESET_BYTE;
         rise_watch_r <= 96'h0;
         fall_watch_r <= 96'h0;
         route_en_r   <= 96'h0;
      end
      else if (wr_in)
      begin
         if (addr_in == `ADDR_INTERRUPT_ENABLE)
            int_enable_r <= wdata_in & `EN_WRITE_MASK;
         for (p = 0; p < `NUM_PORTS; p = p + 1)
         begin
            if (is_port_reg(addr_in, `ADDR_RISE_WATCH_BASE)
                && port_of(addr_in, `ADDR_RISE_WATCH_BASE) == p)
               rise_watch_r[p*8 +: 8] <= wdata_in;
            if (is_port_reg(addr_in, `ADDR_FALL_WATCH_BASE)
                && port_of(addr_in, `ADDR_FALL_WATCH_BASE) == p)
               fall_watch_r[p*8 +: 8] <= wdata_in;
            if (is_port_reg(addr_in, `ADDR_ROUTE_BASE)
                && port_of(addr_in, `ADDR_ROUTE_BASE) == p)
               route_en_r[p*8 +: 8] <= wdata_in;
         end
      end
   end

   // -----------------------------------------------------------
   // trigger routing: first output port, plus line 0 of the second
   // on the star-trigger variant
   // -----------------------------------------------------------
   reg [95:0] route_mask;
   reg [1:0]  seen;
   integer    q;
   always @*
   begin
      route_mask = 96'h0;
      seen = 2'd0;
      for (q = 0; q < `NUM_PORTS; q = q + 1)
      begin
         if (port_output_in[q])
         begin
            if (seen == 2'd0)
               route_mask[q*8 +: 8] = 8'hFF;
            else if (seen == 2'd1 && STAR_VARIANT)
               route_mask[q*8] = 1'b1;
            if (seen != 2'd2)
               seen = seen + 2'd1;
         end
      end
   end
   // port direction is static configuration, not a line sample
   assign route_lines_out = route_en_r & route_mask;

   // -----------------------------------------------------------
   // read data, one cycle after the strobe; unmapped reads zero
   // -----------------------------------------------------------
   reg [7:0] rd_mux;
   integer   r;
   always @*
   begin
      rd_mux = 8'h00;
      case (addr_in)
         `ADDR_BOARD_IDENTITY:   rd_mux = BOARD_ID;
         `ADDR_CHANGE_STATUS:
            rd_mux = {2'b00, wdog_flag_r, fall_flag_r, rise_flag_r,
                      irq_out, overrun_flag_r, edge_flag_r};
         `ADDR_INTERRUPT_ENABLE: rd_mux = int_enable_r;
         default:
         begin
            for (r = 0; r < `NUM_PORTS; r = r + 1)
            begin
               if (is_port_reg(addr_in, `ADDR_RISE_WATCH_BASE)
                   && port_of(addr_in, `ADDR_RISE_WATCH_BASE) == r)
                  rd_mux = rise_watch_r[r*8 +: 8];
               if (is_port_reg(addr_in, `ADDR_FALL_WATCH_BASE)
                   && port_of(addr_in, `ADDR_FALL_WATCH_BASE) == r)
                  rd_mux = fall_watch_r[r*8 +: 8];
               if (is_port_reg(addr_in, `ADDR_ROUTE_BASE)
                   && port_of(addr_in, `ADDR_ROUTE_BASE) == r)
                  rd_mux = route_en_r[r*8 +: 8];
            end
         end
      endcase
   end

   always @(posedge clk_in or negedge nrst_in)
   begin
      if (!nrst_in)
         rdata_out <= 8'h00;
      else if (rd_in)
         rdata_out <= rd_mux;
      else
         rdata_out <= 8'h00;
   end

endmodule // change_detect_interrupt_ctrl
`default_nettype wire

/* File: hdl/change_irq_regs.vh */
// register offsets, field positions and reset values of the change interrupt block
`ifndef CHANGE_IRQ_REGS_VH
`define CHANGE_IRQ_REGS_VH
`define ADDR_BOARD_IDENTITY     8'h00
`define ADDR_CLEAR_STROBE       8'h01
`define ADDR_CHANGE_STATUS      8'h02
`define ADDR_INTERRUPT_ENABLE   8'h03
`define ADDR_RISE_WATCH_BASE    8'h42
`define ADDR_FALL_WATCH_BASE    8'h43
`define ADDR_ROUTE_BASE         8'h49
`define PORT_STRIDE             8'h10
`define NUM_PORTS               12
`define CLR_WDOG_IRQ            6
`define CLR_WDOG_KICK           5
`define CLR_WDOG_EXPIRY         4
`define CLR_EDGE                3
`define CLR_OVERRUN             2
`define ST_WDOG                 5
`define ST_FALL                 4
`define ST_RISE                 3
`define ST_MASTER               2
`define ST_OVERRUN              1
`define ST_EDGE                 0
`define EN_WDOG                 5
`define EN_FALL                 4
`define EN_RISE                 3
`define EN_GLOBAL               2
`define EN_OVERRUN              1
`define EN_EDGE                 0
`define EN_WRITE_MASK           8'h3F
`define RESET_BYTE              8'h00
`define BOARD_ID_DEFAULT        8'h5A
`endif
